// ---- common/ccu_pkg.sv ----
// Package of the capture/compare unit: register map, field layout, mode codes
// and the packed carriers for the bus and the output pins.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package ccu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;  // unit_control
  localparam logic [7:0]  OFS_VALUE    = 8'h04;  // capture/compare value pair
  localparam logic [7:0]  OFS_STATUS   = 8'h08;  // flag, latch, pending, prescaler

  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] VALUE_RESET  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Control field layout
  localparam int MODE_LSB  = 0;
  localparam int MODE_MSB  = 3;
  localparam int DUTY_LSB  = 4;
  localparam int DUTY_MSB  = 5;
  localparam int STEER_LSB = 6;
  localparam int STEER_MSB = 7;

  // Status field layout
  localparam int STAT_IRQ     = 0;
  localparam int STAT_LATCH   = 1;
  localparam int STAT_PEND    = 2;
  localparam int STAT_PRE_LSB = 4;
  localparam int STAT_PRE_MSB = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Mode codes of unit_mode_select
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_RSV1     = 4'h1;
  localparam logic [3:0] MODE_CMP_TGL  = 4'h2;
  localparam logic [3:0] MODE_RSV3     = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4TH  = 4'h6;
  localparam logic [3:0] MODE_CAP_16TH = 4'h7;
  localparam logic [3:0] MODE_CMP_SET  = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SWI  = 4'hA;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
  localparam logic [1:0] MODE_HI_PWM   = 2'h3;

  // Output steering codes in PWM
  localparam logic [1:0] STEER_SINGLE  = 2'h0;
  localparam logic [1:0] STEER_FWD     = 2'h1;
  localparam logic [1:0] STEER_HALF    = 2'h2;
  localparam logic [1:0] STEER_REV     = 2'h3;

  // Prescaler terminal counts
  localparam logic [1:0] PRE4_LAST     = 2'h3;
  localparam logic [3:0] PRE16_LAST    = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ccu_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ccu_wb_rsp_t;

  // Level of each output and whether the unit owns it (else port use)
  typedef struct packed {
    logic [3:0] level;  // {d, c, b, a}
    logic [3:0] own;    // {d, c, b, a}
  } ccu_pins_t;

endpackage : ccu_pkg

// ---- logic/ccu_top.sv ----
// Capture/compare unit with steering of the four PWM outputs.
// Assumes a classic Wishbone master on core_clk, a reference timer and a
// PWM timebase engine on the same clock, and a port mux that honours the
// ownership bits for outputs a..d.
//
// Notes on behaviour
// - Mode zero stops unit; 0001, 0011 inert.
// - Capture on fall, rise, 4th or 16th rise.
// - Mode 0010 toggles output, sets flag on match.
// - Modes 1000/1001 set/clear output, set flag.
// - Mode 1010 sets flag, pin untouched.
// - Mode 1011 flags, resets timer, starts conversion.
// - Codes 1100..1111 pick PWM pair polarities.
// - Outside PWM only output a is used.
// - Steering 00 single, 01 forward, 10 half.
// - Steering 11 gives full-bridge reverse drive.
// - Duty low bits used only in PWM.
// - Capture copies the whole 16-bit timer.
// - Capture sets flag; only software clears it.
// - Newer capture overwrites unread older value.
// - Edge detector watches the pin level itself.
// - Prescaler cleared when off or not capturing.
// - Prescaler kept across capture prescale changes.
// - Compare value checked against timer every cycle.
// - Trigger at match; reset at next tick, cancellable.
// - Trigger never sets timer overflow flag.
// - Clearing control forces compare latch low.
`timescale 1ns/100ps

module ccu_top #(
  parameter int TIMER_W = 16                          // reference timer width
) (
  input  wire logic                 core_clk,         // system clock, 100 MHz
  input  wire logic                 rst_b,            // async reset, active low
  input  wire ccu_pkg::ccu_wb_req_t wb_req,           // Wishbone request
  output      ccu_pkg::ccu_wb_rsp_t wb_rsp,           // Wishbone answer
  input  wire logic [TIMER_W-1:0]   ref_timer_count,  // reference timer value
  input  wire logic                 ref_timer_tick,   // timer clock edge strobe
  input  wire logic                 event_pin_in,     // pad level of output a
  input  wire logic                 pwm_mod_raw,      // modulated level, timebase
  input  wire logic                 adc_enabled,      // converter is enabled
  output      ccu_pkg::ccu_pins_t   pins,             // outputs a..d and ownership
  output      logic                 unit_irq_flag,    // interrupt request flag
  output      logic                 event_trigger,    // special event trigger pulse
  output      logic                 timer_reset,      // timer reset pulse
  output      logic                 adc_start,        // conversion start pulse
  output      logic [9:0]           pwm_duty          // 10-bit duty for timebase
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]         ctrl_r;
  logic [7:0]         ctrl_nxt;
  logic [TIMER_W-1:0] value_r;
  logic [TIMER_W-1:0] value_nxt;
  logic               irq_r;
  logic               irq_nxt;
  logic               latch_r;
  logic               latch_nxt;
  logic               pend_r;
  logic               pend_nxt;
  logic [3:0]         pre_r;
  logic [3:0]         pre_nxt;
  logic               match_prev_r;
  logic               pin_s1_r;
  logic               pin_s2_r;
  logic               pin_s3_r;
  logic               ack_r;
  logic [31:0]        rdat_r;
  logic [31:0]        rdat_nxt;
  ccu_pkg::ccu_pins_t pins_r;
  ccu_pkg::ccu_pins_t pins_nxt;
  logic               trig_r;
  logic               trig_nxt;
  logic               treset_r;
  logic               treset_nxt;
  logic               adc_r;
  logic               adc_nxt;
  logic [9:0]         duty_r;
  logic [9:0]         duty_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  wire [3:0] mode  = ctrl_r[ccu_pkg::MODE_MSB:ccu_pkg::MODE_LSB];
  wire [1:0] steer = ctrl_r[ccu_pkg::STEER_MSB:ccu_pkg::STEER_LSB];
  wire [1:0] duty_low_bits = ctrl_r[ccu_pkg::DUTY_MSB:ccu_pkg::DUTY_LSB];

  wire is_off  = (mode == ccu_pkg::MODE_OFF);
  wire is_pwm  = (mode[3:2] == ccu_pkg::MODE_HI_PWM);
  wire is_cap  = (mode == ccu_pkg::MODE_CAP_FALL) | (mode == ccu_pkg::MODE_CAP_RISE)
               | (mode == ccu_pkg::MODE_CAP_4TH)  | (mode == ccu_pkg::MODE_CAP_16TH);
  // Reserved codes fall in none of these groups, so nothing acts
  wire is_drive = (mode == ccu_pkg::MODE_CMP_TGL) | (mode == ccu_pkg::MODE_CMP_SET)
                | (mode == ccu_pkg::MODE_CMP_CLR);
  wire is_cmp  = is_drive | (mode == ccu_pkg::MODE_CMP_SWI)
               | (mode == ccu_pkg::MODE_CMP_TRIG);
  wire is_trig = (mode == ccu_pkg::MODE_CMP_TRIG);

  // Polarity: 1 means active-low; bit 1 covers a/c, bit 0 covers b/d
  wire pol_ac = mode[1];
  wire pol_bd = mode[0];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire bus_req  = wb_req.cyc & wb_req.stb;
  wire bus_take = bus_req & ~ack_r;
  wire wr_take  = bus_take & wb_req.we;
  wire hit_ctrl = (wb_req.adr == ccu_pkg::OFS_CTRL);
  wire hit_val  = (wb_req.adr == ccu_pkg::OFS_VALUE);
  wire hit_stat = (wb_req.adr == ccu_pkg::OFS_STATUS);

  wire ctrl_wr  = wr_take & hit_ctrl & wb_req.sel[0];
  wire val_wr_lo = wr_take & hit_val & wb_req.sel[0];
  // High byte is read-only while the timebase double-buffers the duty
  wire val_wr_hi = wr_take & hit_val & wb_req.sel[1] & ~is_pwm;
  wire val_wr   = val_wr_lo | val_wr_hi;
  wire irq_w1c  = wr_take & hit_stat & wb_req.sel[0] & wb_req.dat[ccu_pkg::STAT_IRQ];
  wire ctrl_zero = ctrl_wr & (wb_req.dat[7:0] == ccu_pkg::CTRL_RESET);

  ////////////////////////////////////////////////////////////////////////////
  // Capture path: edges seen on the synchronised pad, never on the port latch,
  // so a port write that moves a driven pin is captured too
  wire pin_rise = pin_s2_r & ~pin_s3_r;
  wire pin_fall = ~pin_s2_r & pin_s3_r;

  wire pre_4th  = pin_rise & (pre_r[1:0] == ccu_pkg::PRE4_LAST);
  wire pre_16th = pin_rise & (pre_r == ccu_pkg::PRE16_LAST);

  wire cap_evt = ((mode == ccu_pkg::MODE_CAP_FALL) & pin_fall)
               | ((mode == ccu_pkg::MODE_CAP_RISE) & pin_rise)
               | ((mode == ccu_pkg::MODE_CAP_4TH)  & pre_4th)
               | ((mode == ccu_pkg::MODE_CAP_16TH) & pre_16th);

  ////////////////////////////////////////////////////////////////////////////
  // Compare path; acting on the first cycle of equality keeps a stalled
  // timer from toggling the output every clock
  wire match_now = is_cmp & (value_r == ref_timer_count);
  wire match_evt = match_now & ~match_prev_r;
  wire cmp_flag  = match_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Control and value registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr) begin
      ctrl_nxt = wb_req.dat[7:0];
    end
  end

  always_comb begin
    value_nxt = value_r;
    if (val_wr_lo) begin
      value_nxt[7:0] = wb_req.dat[7:0];
    end
    if (val_wr_hi) begin
      value_nxt[TIMER_W-1:8] = wb_req.dat[TIMER_W-1:8];
    end
    // Capture wins over software and over an unread earlier capture
    if (cap_evt) begin
      value_nxt = ref_timer_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag: set by captures and by matches, cleared only by software; a set in
  // the same cycle as the clear wins
  always_comb begin
    irq_nxt = irq_r;
    if (irq_w1c) begin
      irq_nxt = 1'b0;
    end
    if (cap_evt | cmp_flag) begin
      irq_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare output latch, separate from the port data latch
  always_comb begin
    latch_nxt = latch_r;
    if (match_evt) begin
      unique case (mode)
        ccu_pkg::MODE_CMP_TGL: latch_nxt = ~latch_r;
        ccu_pkg::MODE_CMP_SET: latch_nxt = 1'b1;
        ccu_pkg::MODE_CMP_CLR: latch_nxt = 1'b0;
        default:               latch_nxt = latch_r;
      endcase
    end
    if (is_off | ctrl_zero) begin
      latch_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: not cleared when only the prescale choice changes
  always_comb begin
    pre_nxt = pre_r;
    if (!is_cap) begin
      pre_nxt = '0;
    end else if (pin_rise) begin
      pre_nxt = pre_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Special event: trigger at once, timer reset at the next timer tick unless
  // the match was removed meanwhile. No overflow flag is touched here.
  always_comb begin
    pend_nxt   = pend_r;
    treset_nxt = 1'b0;
    trig_nxt   = match_evt & is_trig;
    adc_nxt    = match_evt & is_trig & adc_enabled;
    if (pend_r & ref_timer_tick) begin
      treset_nxt = ~val_wr & (value_r == ref_timer_count);
      pend_nxt   = 1'b0;
    end
    if (val_wr) begin
      pend_nxt = 1'b0;
    end
    if (match_evt & is_trig) begin
      pend_nxt = 1'b1;
    end
    if (!is_trig) begin
      pend_nxt   = 1'b0;
      treset_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output steering
  wire lvl_mod_ac = pwm_mod_raw ^ pol_ac;
  wire lvl_mod_bd = pwm_mod_raw ^ pol_bd;
  wire lvl_act_ac = ~pol_ac;
  wire lvl_act_bd = ~pol_bd;
  wire lvl_off_ac = pol_ac;
  wire lvl_off_bd = pol_bd;
  // Half-bridge b is the complement of a; dead-band shaping sits downstream
  wire lvl_cmp_bd = ~pwm_mod_raw ^ pol_bd;

  always_comb begin
    pins_nxt.level = 4'h0;
    pins_nxt.own   = 4'h0;
    if (is_pwm) begin
      unique case (steer)
        ccu_pkg::STEER_SINGLE: begin
          pins_nxt.level = {1'b0, 1'b0, 1'b0, lvl_mod_ac};
          pins_nxt.own   = 4'h1;
        end
        ccu_pkg::STEER_FWD: begin
          pins_nxt.level = {lvl_mod_bd, lvl_off_ac, lvl_off_bd, lvl_act_ac};
          pins_nxt.own   = 4'hF;
        end
        ccu_pkg::STEER_HALF: begin
          pins_nxt.level = {1'b0, 1'b0, lvl_cmp_bd, lvl_mod_ac};
          pins_nxt.own   = 4'h3;
        end
        ccu_pkg::STEER_REV: begin
          pins_nxt.level = {lvl_off_bd, lvl_act_ac, lvl_mod_bd, lvl_off_ac};
          pins_nxt.own   = 4'hF;
        end
      endcase
    end else if (is_drive) begin
      // Only a is driven; b, c, d stay with the port whatever steering says
      pins_nxt.level = {3'b000, latch_nxt};
      pins_nxt.own   = 4'h1;
    end
  end

  // Duty low bits reach the timebase only in PWM
  always_comb begin
    duty_nxt = 10'h000;
    if (is_pwm) begin
      duty_nxt = {value_r[7:0], duty_low_bits};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero and are still acknowledged
  always_comb begin
    rdat_nxt = 32'h0000_0000;
    if (hit_ctrl) begin
      rdat_nxt[7:0] = ctrl_r;
    end else if (hit_val) begin
      rdat_nxt[TIMER_W-1:0] = value_r;
    end else if (hit_stat) begin
      rdat_nxt[ccu_pkg::STAT_IRQ]   = irq_r;
      rdat_nxt[ccu_pkg::STAT_LATCH] = latch_r;
      rdat_nxt[ccu_pkg::STAT_PEND]  = pend_r;
      rdat_nxt[ccu_pkg::STAT_PRE_MSB:ccu_pkg::STAT_PRE_LSB] = pre_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= event_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r       <= ccu_pkg::CTRL_RESET;
      value_r      <= ccu_pkg::VALUE_RESET;
      irq_r        <= 1'b0;
      latch_r      <= 1'b0;
      pend_r       <= 1'b0;
      pre_r        <= '0;
      match_prev_r <= 1'b0;
    end else begin
      ctrl_r       <= ctrl_nxt;
      value_r      <= value_nxt;
      irq_r        <= irq_nxt;
      latch_r      <= latch_nxt;
      pend_r       <= pend_nxt;
      pre_r        <= pre_nxt;
      match_prev_r <= match_now;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r    <= 1'b0;
      rdat_r   <= 32'h0000_0000;
      pins_r   <= '0;
      trig_r   <= 1'b0;
      treset_r <= 1'b0;
      adc_r    <= 1'b0;
      duty_r   <= 10'h000;
    end else begin
      ack_r    <= bus_take;
      rdat_r   <= bus_take ? rdat_nxt : 32'h0000_0000;
      pins_r   <= pins_nxt;
      trig_r   <= trig_nxt;
      treset_r <= treset_nxt;
      adc_r    <= adc_nxt;
      duty_r   <= duty_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_rsp.ack    = ack_r;
  assign wb_rsp.dat    = rdat_r;
  assign pins          = pins_r;
  assign unit_irq_flag = irq_r;
  assign event_trigger = trig_r;
  assign timer_reset   = treset_r;
  assign adc_start     = adc_r;
  assign pwm_duty      = duty_r;

endmodule : ccu_top

// ---- test/ccu_top_asserts.sv ----
// Checker of the capture/compare unit, bound to ccu_top.
// Sees only the top ports; follows the control byte from taken bus writes.
`timescale 1ns/100ps
module ccu_top_asserts #(
  parameter int TIMER_W = 16                        // timer width
) (
  input wire logic                 core_clk,        // clock
  input wire logic                 rst_b,           // reset, active low
  input wire ccu_pkg::ccu_wb_req_t wb_req,          // bus request
  input wire ccu_pkg::ccu_wb_rsp_t wb_rsp,          // bus answer
  input wire logic [TIMER_W-1:0]   ref_timer_count, // timer value
  input wire logic                 ref_timer_tick,  // timer tick
  input wire logic                 event_pin_in,    // pad level
  input wire logic                 pwm_mod_raw,     // modulated level
  input wire logic                 adc_enabled,     // converter on
  input wire ccu_pkg::ccu_pins_t   pins,            // outputs a..d
  input wire logic                 unit_irq_flag,   // flag
  input wire logic                 event_trigger,   // trigger pulse
  input wire logic                 timer_reset,     // timer reset pulse
  input wire logic                 adc_start,       // conversion start
  input wire logic [9:0]           pwm_duty         // duty value
);
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  wire        taken   = wb_req.cyc & wb_req.stb & wb_req.we & ~wb_rsp.ack;
  wire        ctrl_wr = taken & wb_req.sel[0] & (wb_req.adr == ccu_pkg::OFS_CTRL);
  wire        val_wr  = taken & (wb_req.adr == ccu_pkg::OFS_VALUE);
  wire        flag_wc = taken & wb_req.sel[0] & wb_req.dat[0] & (wb_req.adr == ccu_pkg::OFS_STATUS);
  wire        pwm_now = ctrl_r[3:2] == 2'h3;
  assign ctrl_nxt = ctrl_wr ? wb_req.dat[7:0] : ctrl_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) ctrl_r <= 8'h00;
    else ctrl_r <= ctrl_nxt;
  end
  ////////////////////////////////////////////////////////////
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held over one cycle");
  a_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("request not answered next cycle");
  a_rdat_idle: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
    else $error("read data outside ack");
  a_flag_sticky: assert property ($fell(unit_irq_flag) |-> $past(flag_wc))
    else $error("flag cleared without software");
  a_pins_outside_pwm: assert property (!pwm_now && !$past(pwm_now) |-> pins.own[3:1] == 3'h0)
    else $error("b, c or d owned outside PWM");
  a_duty_outside_pwm: assert property (!pwm_now && !$past(pwm_now) |-> pwm_duty == 10'h000)
    else $error("duty driven outside PWM");
  a_off_state: assert property (ctrl_r == 8'h00 && $past(ctrl_r) == 8'h00 |->
    pins.own == 4'h0 && !pins.level[0]) else $error("unit not idle when off");
  a_rev_bridge: assert property ((ctrl_r & 8'hCF) == 8'hCC && ($past(ctrl_r) & 8'hCF) == 8'hCC
    |-> !pins.level[3] && pins.level[2] && !pins.level[0]) else $error("reverse drive wrong");
  a_trig_effects: assert property (event_trigger |-> unit_irq_flag &&
    ($past(ctrl_r) & 8'h0F) == 8'h0B && adc_start == $past(adc_enabled))
    else $error("trigger without its effects");
  a_reset_after_tick: assert property (timer_reset |-> $past(ref_timer_tick) &&
    !$past(val_wr) && !$past(timer_reset)) else $error("timer reset out of turn");
  c_capture: cover property ($rose(unit_irq_flag) && ctrl_r[3:2] == 2'h1);
  c_trigger: cover property (event_trigger && adc_start);
  c_reset: cover property (timer_reset);
endmodule : ccu_top_asserts

bind ccu_top ccu_top_asserts #(.TIMER_W(TIMER_W)) u_asserts (
  .core_clk(core_clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
  .ref_timer_count(ref_timer_count), .ref_timer_tick(ref_timer_tick),
  .event_pin_in(event_pin_in), .pwm_mod_raw(pwm_mod_raw), .adc_enabled(adc_enabled),
  .pins(pins), .unit_irq_flag(unit_irq_flag), .event_trigger(event_trigger),
  .timer_reset(timer_reset), .adc_start(adc_start), .pwm_duty(pwm_duty)
);

// ---- test/ccu_pin_model.sv ----
// Far side of the event pin: an outside source and the port output driver.
// Assumes the bench moves both levels just after a clock edge.
`timescale 1ns/100ps
module ccu_pin_model (
  input  wire logic src_level,  // outside source level
  input  wire logic port_oe_b,  // port driver enable, active low
  input  wire logic port_level, // port data latch
  output      logic pad         // level on the pin
);
  // The unit watches the pad, so a port write edge counts like a source edge
  assign pad = !port_oe_b ? port_level : src_level;
endmodule : ccu_pin_model

// ---- test/capture_compare_unit_tb_top.sv ----
// Bench of the capture/compare unit: bus tasks, pin model, one task a scenario.
// Assumes one 100 MHz clock; the bench drives the timer on that same clock.
`timescale 1ns/100ps
module capture_compare_unit_tb_top;
  logic                 core_clk;
  logic                 rst_b;
  ccu_pkg::ccu_wb_req_t wb_req;
  ccu_pkg::ccu_wb_rsp_t wb_rsp;
  ccu_pkg::ccu_pins_t   pins;
  logic [15:0]          tmr;
  logic [9:0]           duty;
  logic [31:0]          rd;
  logic                 tick, pad, src_level, port_oe_b, port_level, mod_raw, adc_en;
  logic                 irq, trig, trst, adc_go;
  int                   fails = 0, cmp_count = 0, trig_n = 0, trst_n = 0, adc_n = 0;

  ccu_top #(.TIMER_W(16)) DUT (
    .core_clk(core_clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .ref_timer_count(tmr), .ref_timer_tick(tick), .event_pin_in(pad),
    .pwm_mod_raw(mod_raw), .adc_enabled(adc_en), .pins(pins), .unit_irq_flag(irq),
    .event_trigger(trig), .timer_reset(trst), .adc_start(adc_go), .pwm_duty(duty)
  );
  ccu_pin_model u_pin (
    .src_level(src_level), .port_oe_b(port_oe_b), .port_level(port_level), .pad(pad)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Pulses are counted so that a missed or doubled one shows up later
  always @(posedge core_clk) begin
    trig_n <= trig_n + int'(trig === 1'b1);
    trst_n <= trst_n + int'(trst === 1'b1);
    adc_n  <= adc_n + int'(adc_go === 1'b1);
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge core_clk);
    end while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
    check({31'h0, wb_rsp.ack}, 32'h1);
  endtask : wb

  task automatic set_mode(input logic [7:0] c);
    wb(1'b1, ccu_pkg::OFS_CTRL, 32'h0);
    wb(1'b1, ccu_pkg::OFS_CTRL, {24'h0, c});
    wb(1'b1, ccu_pkg::OFS_STATUS, 32'h1);
  endtask : set_mode

  task automatic pulse(input int w);
    @(posedge core_clk);
    if (!port_oe_b) port_level <= 1'b1;
    else src_level <= 1'b1;
    repeat (w) @(posedge core_clk);
    if (!port_oe_b) port_level <= 1'b0;
    else src_level <= 1'b0;
    repeat (w) @(posedge core_clk);
  endtask : pulse
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] adrs [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, adrs[i], 32'h0);
      check(rd, 32'h0);
    end
    wb(1'b1, 8'h0C, 32'hFF);
    wb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0);
    for (int i = 1; i < 4; i += 2) begin
      wb(1'b1, ccu_pkg::OFS_CTRL, 32'(i));
      repeat (3) @(posedge core_clk);
      check({23'h0, pins, irq}, 32'h0);
      wb(1'b0, ccu_pkg::OFS_CTRL, 32'h0);
      check(rd, 32'(i));
    end
  endtask : t_regs

  task automatic t_capture(input logic [3:0] m, input int n);
    set_mode({4'h0, m});
    for (int i = 1; i <= n; i++) begin
      tmr <= 16'h0101 * 16'(i);
      pulse(4 + i % 3);
      if (m[1] && i == n - 1) begin
        wb(1'b0, ccu_pkg::OFS_STATUS, 32'h0);
        check(rd & 32'h1, 32'h0);
      end
    end
    wb(1'b0, ccu_pkg::OFS_STATUS, 32'h0);
    check(rd & 32'h1, 32'h1);
    wb(1'b0, ccu_pkg::OFS_VALUE, 32'h0);
    check(rd, {16'h0, 16'h0101 * 16'(n)});
    wb(1'b1, ccu_pkg::OFS_STATUS, 32'h1);
    wb(1'b0, ccu_pkg::OFS_STATUS, 32'h0);
    check(rd & 32'h1, 32'h0);
  endtask : t_capture

  task automatic t_prescale;
    set_mode(8'h06);
    pulse(4);
    pulse(4);
    wb(1'b0, ccu_pkg::OFS_STATUS, 32'h0);
    check(rd & 32'hF0, 32'h20);
    wb(1'b1, ccu_pkg::OFS_CTRL, 32'h07);
    wb(1'b0, ccu_pkg::OFS_STATUS, 32'h0);
    check(rd & 32'hF0, 32'h20);
    wb(1'b1, ccu_pkg::OFS_CTRL, 32'h0);
    wb(1'b0, ccu_pkg::OFS_STATUS, 32'h0);
    check(rd & 32'hF0, 32'h0);
  endtask : t_prescale

  task automatic t_compare;
    logic [3:0]  modes [4] = '{4'h8, 4'h9, 4'h2, 4'hA};
    logic [31:0] stat [4]  = '{32'h3, 32'h1, 32'h3, 32'h3};
    logic [31:0] pin [4]   = '{32'h3, 32'h2, 32'h3, 32'h0};
    wb(1'b1, ccu_pkg::OFS_VALUE, 32'h0050);
    for (int i = 0; i < 4; i++) begin
      tmr <= 16'h004F;
      // Direct switches keep the latch, so clear, toggle and hold all show
      wb(1'b1, ccu_pkg::OFS_CTRL, {28'h0, modes[i]});
      wb(1'b1, ccu_pkg::OFS_STATUS, 32'h1);
      repeat (2) @(posedge core_clk);
      tmr <= 16'h0050;
      repeat (3) @(posedge core_clk);
      check({30'h0, pins.own[0], pins.level[0] & pins.own[0]}, pin[i]);
      wb(1'b0, ccu_pkg::OFS_STATUS, 32'h0);
      check(rd & 32'h3, stat[i]);
    end
    wb(1'b1, ccu_pkg::OFS_CTRL, 32'h0);
    wb(1'b0, ccu_pkg::OFS_STATUS, 32'h0);
    check(rd & 32'h2, 32'h0);
  endtask : t_compare

  task automatic t_trigger;
    tmr <= 16'h007F;
    adc_en <= 1'b1;
    wb(1'b1, ccu_pkg::OFS_VALUE, 32'h0080);
    set_mode(8'h0B);
    tmr <= 16'h0080;
    repeat (4) @(posedge core_clk);
    check({trig_n[15:0], adc_n[15:0]}, 32'h0001_0001);
    check({31'h0, irq}, 32'h1);
    check(trst_n, 0);
    for (int k = 0; k < 2; k++) begin
      tick <= 1'b1;
      @(posedge core_clk);
      tick <= 1'b0;
      repeat (3) @(posedge core_clk);
      check(trst_n, 1);
      tmr <= 16'h007F;
      adc_en <= 1'b0;
      repeat (2) @(posedge core_clk);
      tmr <= 16'h0080 + 16'(k);
      repeat (4) @(posedge core_clk);
      check({trig_n[15:0], adc_n[15:0]}, {16'(k + 2), 16'h1});
      wb(1'b1, ccu_pkg::OFS_VALUE, 32'(16'h0081 + k));
    end
  endtask : t_trigger

  task automatic t_pwm;
    logic [3:0] drv [4] = '{4'h1, 4'h9, 4'h1, 4'h6};
    logic [3:0] own [4] = '{4'h1, 4'hF, 4'h3, 4'hF};
    logic [3:0] pol;
    wb(1'b1, ccu_pkg::OFS_VALUE, 32'h00A5);
    mod_raw <= 1'b1;
    for (int m = 12; m < 16; m++) begin
      for (int s = 0; s < 4; s++) begin
        wb(1'b1, ccu_pkg::OFS_CTRL, 32'(s * 64 + 32 + m));
        repeat (3) @(posedge core_clk);
        pol = {m[0], m[1], m[0], m[1]};
        check({28'h0, pins.own}, {28'h0, own[s]});
        check({28'h0, pins.level & pins.own}, {28'h0, (drv[s] ^ pol) & own[s]});
        check({22'h0, duty}, 32'h0296);
      end
    end
    wb(1'b1, ccu_pkg::OFS_CTRL, 32'h0);
  endtask : t_pwm
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    rst_b = 1'b0;
    wb_req = '0;
    tmr = 16'h0000;
    {tick, src_level, port_level, mod_raw, adc_en} = 5'h00;
    port_oe_b = 1'b1;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_capture(4'h4, 1);
    port_oe_b <= 1'b0;
    t_capture(4'h5, 2);
    port_oe_b <= 1'b1;
    t_capture(4'h6, 4);
    t_capture(4'h7, 16);
    t_prescale();
    t_compare();
    t_trigger();
    t_pwm();
    report_and_stop();
  end

  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule : capture_compare_unit_tb_top
